/* verilog/axi_memory_read_port.sv */
// read channels of an axi4 subordinate fronting an on-chip block memory
// assumes a synchronous-read memory array held here, one cycle read latency
`timescale 1ns/1ps

module axi_memory_read_port
#(
	parameter bit PERIPHERAL = 1'b0,
	parameter bit USE_ID     = 1'b1,
	parameter int ID_W       = 4,
	parameter int DATA_W     = 32,
	parameter int DEPTH      = 1024
)
(
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic [ID_W-1:0]   s_axi_arid,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic [7:0]        s_axi_arlen,
	input  wire logic [2:0]        s_axi_arsize,
	input  wire logic [1:0]        s_axi_arburst,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [ID_W-1:0]        s_axi_rid,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rlast,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              memWrEn,
	input  wire logic [$clog2(DEPTH)-1:0] memWrAddr,
	input  wire logic [DATA_W-1:0] memWrData
);
	import axi_rd_pkg::*;

	localparam int BYTES = DATA_W / 8;
	localparam int AW    = $clog2(DEPTH);
	localparam int BSH   = (BYTES > 1) ? $clog2(BYTES) : 0;

	// ---------------------------------------------------------------
	// memory array
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] memOut;

	rd_state_t   state;
	rd_state_t   next_state;
	rd_cmd_t     cmd;
	rd_cmd_t     next_cmd;
	logic [7:0]  beats;
	logic [7:0]  next_beats;
	logic        arReady;
	logic        next_arReady;
	logic        rValid;
	logic        next_rValid;
	logic        rLast;
	logic        next_rLast;
	logic [31:0] nextAddr;
	logic [31:0] wrapMask;
	logic [2:0]  effSize;
	logic [1:0]  effBurst;

	always_ff @(posedge mclk)
	begin
		if (memWrEn)
			mem[memWrAddr] <= memWrData;
		memOut <= mem[cmd.addr[BSH +: AW]];
	end

	// ---------------------------------------------------------------
	// burst address arithmetic
	// ---------------------------------------------------------------
	always_comb
	begin
		effSize  = PERIPHERAL ? 3'(BSH) : cmd.size;
		effBurst = PERIPHERAL ? BURST_INCR : cmd.burst;
		// wrap window is (len+1) beats of 2**size bytes; len is 1,3,7,15 for wrap
		wrapMask = ({24'h000000, cmd.len} << effSize) | ((32'h1 << effSize) - 32'h1);
		nextAddr = (cmd.addr & ~((32'h1 << effSize) - 32'h1)) + (32'h1 << effSize);
		if (effBurst == BURST_WRAP)
			nextAddr = (cmd.addr & ~wrapMask) | (nextAddr & wrapMask);
	end

	// ---------------------------------------------------------------
	// read sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state   = state;
		next_cmd     = cmd;
		next_beats   = beats;
		next_arReady = arReady;
		next_rValid  = rValid;
		next_rLast   = rLast;
		case (state)
			IDLE:
			begin
				if (arReady && s_axi_arvalid)
				begin
					// fields are stable while arvalid waits, so one capture suffices
					next_cmd.addr  = s_axi_araddr;
					next_cmd.len   = s_axi_arlen;
					next_cmd.size  = s_axi_arsize;
					next_cmd.burst = PERIPHERAL ? BURST_INCR : s_axi_arburst;
					next_cmd.id    = (USE_ID && !PERIPHERAL) ? 16'(s_axi_arid) : 16'h0000;
					next_beats     = s_axi_arlen;
					next_arReady   = 1'b0;
					next_state     = FETCH;
				end
				else if (!arReady)
				begin
					// first cycle out of reset: open the address channel
					next_arReady = 1'b1;
				end
			end
			FETCH:
			begin
				// memory output is registered at the end of this cycle; raise rvalid with it
				next_rValid = 1'b1;
				next_rLast  = (beats == 8'h00);
				next_state  = SEND;
			end
			SEND:
			begin
				if (rValid && s_axi_rready)
				begin
					next_rValid = 1'b0;
					next_rLast  = 1'b0;
					if (beats == 8'h00)
					begin
						next_arReady = 1'b1;
						next_state   = IDLE;
					end
					else
					begin
						next_beats    = beats - 8'h01;
						next_cmd.addr = nextAddr;
						next_state    = FETCH;
					end
				end
			end
			default:
			begin
				next_state = IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state   <= IDLE;
			cmd     <= '0;
			beats   <= BEATS_RESET;
			arReady <= 1'b0;
			rValid  <= 1'b0;
			rLast   <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			cmd     <= next_cmd;
			beats   <= next_beats;
			arReady <= next_arReady;
			rValid  <= next_rValid;
			rLast   <= next_rLast;
		end
	end

	// ---------------------------------------------------------------
	// outputs; rdata is the memory register, held stable while rvalid waits unless memWrEn writes the addressed word
	// ---------------------------------------------------------------
	assign s_axi_arready = arReady;
	assign s_axi_rvalid  = rValid;
	assign s_axi_rlast   = rLast;
	assign s_axi_rdata   = memOut;
	assign s_axi_rid     = ID_W'(cmd.id);
	assign s_axi_rresp   = RESP_OKAY;

endmodule

/* verilog/axi_rd_pkg.sv */
// package for the memory read port: constants, burst encodings, state enum, carrier struct
// assumes a single clock domain and an axi4 manager on the far side
package axi_rd_pkg;

	// ---------------------------------------------------------------
	// encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR  = 2'h1;
	localparam logic [1:0] BURST_WRAP  = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] BEATS_RESET = 8'h00;

	typedef enum logic [1:0] {
		IDLE  = 2'b00,
		FETCH = 2'b01,
		SEND  = 2'b11
	} rd_state_t;

	// address and control captured from the read address channel
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  len;
		logic [2:0]  size;
		logic [1:0]  burst;
		logic [15:0] id;
	} rd_cmd_t;

endpackage

/* dv/axi_memory_read_port_assertions.sv */
// checker: read port handshakes and beat framing, bound onto the port
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module axi_memory_read_port_assertions
	import axi_rd_pkg::*;
(
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       s_axi_rlast,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	wire acc = s_axi_arvalid && s_axi_arready;
	wire rv = s_axi_rvalid;
	wire hs = rv && s_axi_rready;
	wire rl = s_axi_rlast;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_ok; rv |-> s_axi_rresp == RESP_OKAY; endproperty
	a_ok: assert property (p_ok) else $error("resp");
	property p_take; acc |=> !s_axi_arready; endproperty
	a_take: assert property (p_take) else $error("take");
	property p_busy; rv |-> !s_axi_arready; endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_first; acc |=> !rv ##1 rv; endproperty
	a_first: assert property (p_first) else $error("first");
	property p_hold; rv && !s_axi_rready |=> rv; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_keep; rv && !s_axi_rready |=> $stable(rl); endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_gap; hs && !rl |=> !rv ##1 rv; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_end; hs && rl |=> !rv && s_axi_arready; endproperty
	a_end: assert property (p_end) else $error("end");
	c_stall: cover property (rv && !s_axi_rready);
	c_beat: cover property (hs && !rl);
	c_end: cover property (hs && rl);
endmodule
bind axi_memory_read_port axi_memory_read_port_assertions i_chk (.*);

/* dv/axi_rd_manager.sv */
// manager model: one read burst per call, beats queued as {id, last, data}
// assumes calls start 1 ns after a rising edge of mclk
`timescale 1ns/1ps
module axi_rd_manager
	import axi_rd_pkg::*;
(
	input wire logic        mclk,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [3:0]  s_axi_rid,
	input wire logic        s_axi_rlast,
	input wire logic [31:0] s_axi_rdata,
	output rd_cmd_t         cmd,
	output logic            s_axi_arvalid,
	output logic            s_axi_rready
);
	logic [36:0] q[$];
	initial {cmd, s_axi_arvalid, s_axi_rready} = '0;
	task automatic burst(rd_cmd_t c, int stall);
		q = {};
		cmd = c;
		s_axi_arvalid = 1'h1;
		do @(posedge mclk); while (!s_axi_arready);
		#1 s_axi_arvalid = 1'h0;
		cmd = ~c; // released lines must not look valid
		s_axi_rready = stall == 0;
		do
		begin
			repeat (stall) @(posedge mclk);
			if (stall > 0) #1 s_axi_rready = 1'h1;
			do @(posedge mclk); while (!s_axi_rvalid);
			q.push_back({s_axi_rid, s_axi_rlast, s_axi_rdata});
			#1 s_axi_rready = stall == 0 && !q[$][32];
		end
		while (!q[$][32]);
	endtask
endmodule

/* dv/axi_memory_read_port_test.sv */
// bench: read port with manager model, memory loaded, then four bursts
// assumes default parameters: 32-bit data, 4-bit ids, memory style
`timescale 1ns/1ps
module axi_memory_read_port_test;
	import axi_rd_pkg::*;
	logic        mclk = 1'h0, reset_n = 1'h0, memWrEn = 1'h0, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rlast, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_rid;
	logic [1:0]  s_axi_rresp;
	logic [31:0] s_axi_rdata, memWrData;
	logic [9:0]  memWrAddr;
	rd_cmd_t     cmd;
	int          fail_count, cmp_count, cyc;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("Error %s exp %h got %h", n, e, g); end end
	always #20 mclk = ~mclk;
	axi_memory_read_port i_dut (.*, .s_axi_arid(cmd.id[3:0]), .s_axi_araddr(cmd.addr),
		.s_axi_arlen(cmd.len), .s_axi_arsize(cmd.size), .s_axi_arburst(cmd.burst));
	axi_rd_manager i_mgr (.*);
	always @(posedge mclk) if (++cyc > 2000) begin fail_count++; print_verdict(); end
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic run(logic [3:0] id, logic [7:0] aw, len, logic [1:0] bt, int stall);
		logic [7:0] w;
		i_mgr.burst('{{22'h0, aw, 2'h0}, len, 3'h2, bt, {12'h0, id}}, stall);
		for (int n = 0; n <= len; n++)
		begin
			w = aw + 8'(n);
			if (bt == BURST_WRAP) w = aw & ~len | w & len;
			`CHK("beat", {id, n == len, 24'ha50000, w}, i_mgr.q[n])
		end
		`CHK("resp", RESP_OKAY, s_axi_rresp)
	endtask
	initial
	begin
		{memWrAddr, memWrData} = '0;
		repeat (2) @(posedge mclk);
		#1 reset_n = 1'h1;
		memWrEn = 1'h1;
		for (int w = 0; w < 16; w++)
		begin
			{memWrAddr, memWrData} = {10'(w), 24'ha50000, 8'(w)};
			@(posedge mclk);
			#1;
		end
		memWrEn = 1'h0;
		run(4'h3, 8'h04, 8'h00, BURST_INCR, 0);
		run(4'h5, 8'h08, 8'h03, BURST_INCR, 3);
		run(4'h9, 8'h0e, 8'h03, BURST_WRAP, 0);
		run(4'ha, 8'h01, 8'h07, BURST_WRAP, 1);
		print_verdict();
	end
endmodule
